// [dv/arc_top_chk.sv]
// Purpose: port-level checks on arc_top
// Assumes: one clock, synchronous active-low reset
// Notes:   register contents are judged by the bench, not here
`default_nettype none
module arc_top_chk (
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic                  s_axi_rvalid,
    input wire logic                  s_axi_rready,
    input wire logic [31:0]           s_axi_rdata,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_bready,
    input wire logic [1:0]            s_axi_bresp,
    input wire logic                  vbus_pin,
    input wire logic                  bias_request,
    input wire logic                  ref_buffer_on,
    input wire logic                  ref_pin_drive,
    input wire logic                  bias_gen_on,
    input wire logic                  vbus_irq,
    input wire logic                  usb_sys_reset,
    input wire logic                  irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_rd_next_cycle: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read");
    a_rd_data_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_wr_resp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rd_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper data");
    a_buf_drive_tied: assert property (
        ref_buffer_on == ref_pin_drive) else $error("buffer and pin differ");
    a_bias_request: assert property (
        bias_request |=> bias_gen_on) else $error("bias not on");
    a_irq_one_pulse: assert property (
        vbus_irq |=> !vbus_irq) else $error("vbus irq too long");
    a_irq_from_edge: assert property (
        vbus_irq |-> $past(vbus_pin, 3) != $past(vbus_pin, 4))
        else $error("vbus irq without edge");
    a_rst_from_edge: assert property (
        $rose(usb_sys_reset) |-> $past(vbus_pin, 3) ^ $past(vbus_pin, 4))
        else $error("usb reset without edge");
    // the main scenarios must have been reached
    c_vbus_irq: cover property (vbus_irq);
    c_usb_reset: cover property (usb_sys_reset);
    c_irq: cover property ($rose(irq));
endmodule : arc_top_chk
bind arc_top arc_top_chk u_chk (.*);
`default_nettype wire

// [dv/tb.sv]
// Purpose: self-checking bench for arc_top
// Assumes: bench is the axi4-lite master and drives vbus itself
// Notes:   ready is sampled at the falling edge, once settled
`include "arc_defs.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 0, aresetn = 0, vbus_pin = 0, bias_request = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    arc_pkg::arc_ref_src_t ref_source;
    logic ref_gain_2x, ref_buffer_on, ref_pin_drive, temp_sensor_on;
    logic bias_gen_on, input_regulator_on, input_regulator_lp;
    logic vbus_irq, usb_sys_reset, irq;
    int error_cnt = 0, n_compared = 0;
    arc_top uut (.*);
    // 50 ns period
    initial forever #25 aclk = ~aclk;
    task automatic chk(input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // master holds each channel until its handshake; no cycle count assumed
    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      input logic [1:0] er);
        logic aw, w, b;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (!b);
        s_axi_bready <= 1'b0;
        chk({30'h0, r}, {30'h0, er});
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] ed,
                      input logic [1:0] er);
        logic ar, v;
        logic [31:0] dat;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            ar = s_axi_arvalid & s_axi_arready;
            v = s_axi_rvalid;
            dat = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
        end while (!v);
        s_axi_rready <= 1'b0;
        chk(dat, {24'h0, ed});
        chk({30'h0, r}, {30'h0, er});
    endtask : rd
    // toggles vbus and counts irq and reset pulses over eight cycles
    task automatic vb(input logic lvl, input logic [15:0] exp);
        logic [7:0] ni, nr;
        ni = 0;
        nr = 0;
        @(posedge aclk);
        vbus_pin <= lvl;
        repeat (8) begin
            @(negedge aclk);
            ni += {7'h0, vbus_irq};
            nr += {7'h0, usb_sys_reset};
        end
        chk({16'h0, ni, nr}, {16'h0, exp});
    endtask : vb
    task automatic t_reg();
        rd(`ARC_REFCTL_ADDR, 8'h00, 2'b00);
        rd(`ARC_REGCTL_ADDR, 8'h00, 2'b00);
        chk({30'h0, input_regulator_on, input_regulator_lp}, 32'h2);
        wr(`ARC_REGCTL_ADDR, 8'hff, 2'b00);
        rd(`ARC_REGCTL_ADDR, 8'hbf, 2'b00);
        chk({30'h0, input_regulator_on, input_regulator_lp}, 32'h1);
        $display("t_reg done");
    endtask : t_reg
    task automatic t_ref();
        wr(`ARC_REFCTL_ADDR, 8'hff, 2'b00);
        rd(`ARC_REFCTL_ADDR, 8'h9f, 2'b00);
        chk({28'h0, ref_gain_2x, ref_buffer_on, ref_pin_drive, temp_sensor_on},
            32'h7);
        chk({31'h0, bias_gen_on}, 32'h1);
        // source and override in every combination
        for (int i = 0; i < 4; i++) begin
            wr(`ARC_REFCTL_ADDR, {3'h0, i[1:0], 3'h0}, 2'b00);
            @(negedge aclk);
            chk({30'h0, ref_source},
                {30'h0, i[1] ? 2'b10 : {1'b0, i[0]}});
        end
        chk({29'h0, ref_gain_2x, temp_sensor_on, bias_gen_on}, 32'h4);
        @(posedge aclk);
        bias_request <= 1'b1;
        repeat (2) @(negedge aclk);
        chk({31'h0, bias_gen_on}, 32'h1);
        $display("t_ref done");
    endtask : t_ref
    task automatic t_vbus();
        wr(`ARC_CTRL_ADDR, 8'h03, 2'b00);
        wr(`ARC_MASK_ADDR, 8'h01, 2'b00);
        vb(1'b1, 16'h0101);
        chk({31'h0, irq}, 32'h1);
        rd(`ARC_REGCTL_ADDR, 8'hff, 2'b00);
        rd(`ARC_STATUS_ADDR, 8'h01, 2'b00);
        vb(1'b0, 16'h0101);
        chk({31'h0, irq}, 32'h0);
        rd(`ARC_STATUS_ADDR, 8'h02, 2'b00);
        wr(`ARC_CTRL_ADDR, 8'h00, 2'b00);
        vb(1'b1, 16'h0000);
        rd(`ARC_REGCTL_ADDR, 8'hff, 2'b00);
        $display("t_vbus done");
    endtask : t_vbus
    task automatic report_and_stop();
        $display("compared %0d mismatched %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reg();
        t_ref();
        t_vbus();
        wr(12'h010, 8'h55, 2'b10);
        rd(12'h010, 8'h00, 2'b10);
        report_and_stop();
    end
    // whole run needs under two hundred cycles
    initial begin
        repeat (3000) @(posedge aclk);
        error_cnt++;
        report_and_stop();
    end
endmodule : tb
`default_nettype wire

// [hdl/arc_defs.svh]
// Purpose: offsets, field positions, reset values and masks for the
//          analog reference and regulator control block
// Assumes: 32-bit AXI4-Lite, one register per aligned word
// Notes:   the two analog registers keep their index; byte address = 4*index
`ifndef ARC_DEFS_SVH
`define ARC_DEFS_SVH

// ----------------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------------
`define ARC_ADDR_W          12
`define ARC_REFCTL_IDX      8'hd1
`define ARC_REGCTL_IDX      8'hc9
`define ARC_REFCTL_ADDR     {2'b00, `ARC_REFCTL_IDX, 2'b00}
`define ARC_REGCTL_ADDR     {2'b00, `ARC_REGCTL_IDX, 2'b00}
`define ARC_CTRL_ADDR       12'h000
`define ARC_STATUS_ADDR     12'h004
`define ARC_MASK_ADDR       12'h008

// ----------------------------------------------------------------------
// reference control fields
// ----------------------------------------------------------------------
`define ARC_REF_BUF_EN_BIT  0
`define ARC_BIAS_EN_BIT     1
`define ARC_TEMP_EN_BIT     2
`define ARC_REF_SRC_BIT     3
`define ARC_REG_OVR_BIT     4
`define ARC_REF_GAIN_BIT    7
`define ARC_REFCTL_WMASK    8'h9f
`define ARC_REFCTL_RESET    8'h00

// ----------------------------------------------------------------------
// regulator control fields
// ----------------------------------------------------------------------
`define ARC_IREG_LP_BIT     4
`define ARC_VBUS_STAT_BIT   6
`define ARC_IREG_DIS_BIT    7
`define ARC_REGCTL_WMASK    8'hbf
`define ARC_REGCTL_RESET    8'h00

// ----------------------------------------------------------------------
// block control, interrupt status and mask
// ----------------------------------------------------------------------
`define ARC_VBUS_IRQ_EN_BIT 0
`define ARC_USB_RST_EN_BIT  1
`define ARC_CTRL_WMASK      8'h03
`define ARC_CTRL_RESET      8'h00
`define ARC_EVT_RISE_BIT    0
`define ARC_EVT_FALL_BIT    1
`define ARC_NUM_EVT         2
`define ARC_MASK_RESET      8'h00

// ----------------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------------
`define ARC_RESP_OKAY       2'b00
`define ARC_RESP_SLVERR     2'b10

`endif

// [hdl/arc_pkg.sv]
// Purpose: shared types of the analog reference and regulator control block
// Assumes: constants live in arc_defs.svh
// Notes:   nothing here is imported; users write arc_pkg::name
`default_nettype none

package arc_pkg;

    // ------------------------------------------------------------------
    // decoded register select
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        arc_reg_none   = 3'b000,
        arc_reg_refctl = 3'b001,
        arc_reg_regctl = 3'b010,
        arc_reg_ctrl   = 3'b011,
        arc_reg_status = 3'b100,
        arc_reg_mask   = 3'b101
    } arc_reg_t;

    // ------------------------------------------------------------------
    // adc reference source actually routed
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        arc_ref_pin  = 2'b00,
        arc_ref_vdd  = 2'b01,
        arc_ref_ireg = 2'b10
    } arc_ref_src_t;

endpackage : arc_pkg

`default_nettype wire

// [hdl/arc_top.sv]
// Purpose: register control of the adc reference selector, reference
//          buffer, temperature sensor, bias generator and input regulator,
//          plus vbus status, vbus interrupt and usb reset on vbus edges
// Assumes: AXI4-Lite slave, 32-bit data, one register per aligned word
// Notes:   analog controls are static levels; ref_source and bias_gen_on are registered one cycle late
//
// What this block does
// R01: reference select bit 3 routes the pin when 0, supply when 1.
// R02: override bit 4 set forces the internal regulator as reference.
// R03: gain bit 7 gives 2x buffer gain when 0, 1x when 1.
// R04: buffer enable bit 0 turns buffer on and drives the reference pin.
// R05: bit 2 switches the temperature sensor off at 0, on at 1.
// R06: bias runs when bit 1 is set or any peripheral requests it.
// R07: bits 6 and 5 of reference control read zero, writes ignored.
// R08: software enables or disables the input regulator by a control bit.
// R09: a mode bit picks normal or low-power input regulator operation.
// R10: bus power status bit reads the present vbus level.
// R11: with its enable set, every vbus edge raises the vbus interrupt.
// R12: the vbus interrupt is an edge pulse with no pending flag.
// R13: with usb reset source set, any vbus edge requests system reset.
// R14: regulator control bit 7 at 1 disables the input regulator.
// R15: regulator control bit 6 is read-only, 1 while vbus is present.
// R16: regulator control bit 4 at 1 selects low-power operation.
// R17: vbus is synchronised and edges come from successive samples.
`include "arc_defs.svh"
`default_nettype none

module arc_top (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // axi4-lite write address
    input  wire logic [`ARC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]             s_axi_awprot,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // axi4-lite read address
    input  wire logic [`ARC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]             s_axi_arprot,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    // axi4-lite read data
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // pins and analog side
    input  wire logic                   vbus_pin,
    input  wire logic                   bias_request,
    output arc_pkg::arc_ref_src_t       ref_source,
    output logic                        ref_gain_2x,
    output logic                        ref_buffer_on,
    output logic                        ref_pin_drive,
    output logic                        temp_sensor_on,
    output logic                        bias_gen_on,
    output logic                        input_regulator_on,
    output logic                        input_regulator_lp,
    output logic                        vbus_irq,
    output logic                        usb_sys_reset,
    output logic                        irq
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // shared by the write and the read path
    function automatic arc_pkg::arc_reg_t arc_decode(
        input logic [`ARC_ADDR_W-1:0] addr
    );
        arc_pkg::arc_reg_t sel;
        if (addr == `ARC_REFCTL_ADDR) begin
            sel = arc_pkg::arc_reg_refctl;
        end else if (addr == `ARC_REGCTL_ADDR) begin
            sel = arc_pkg::arc_reg_regctl;
        end else if (addr == `ARC_CTRL_ADDR) begin
            sel = arc_pkg::arc_reg_ctrl;
        end else if (addr == `ARC_STATUS_ADDR) begin
            sel = arc_pkg::arc_reg_status;
        end else if (addr == `ARC_MASK_ADDR) begin
            sel = arc_pkg::arc_reg_mask;
        end else begin
            sel = arc_pkg::arc_reg_none;
        end
        return sel;
    endfunction : arc_decode

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [`ARC_ADDR_W-1:0]  aw_addr_q;
    logic                    aw_held_q;
    logic [7:0]              w_data_q;
    logic                    w_strb0_q;
    logic                    w_held_q;
    logic                    bvalid_q;
    logic [1:0]              bresp_q;
    logic                    rvalid_q;
    logic [1:0]              rresp_q;
    logic [31:0]             rdata_q;
    logic                    aw_hs;
    logic                    w_hs;
    logic                    ar_hs;
    logic                    do_write;
    arc_pkg::arc_reg_t       wr_sel;
    arc_pkg::arc_reg_t       rd_sel;
    logic                    wr_en;

    logic [7:0]              ref_ctl_q;
    logic [7:0]              reg_ctl_q;
    logic [7:0]              ctrl_q;
    logic [7:0]              mask_q;
    logic [`ARC_NUM_EVT-1:0] stat_q;
    logic [`ARC_NUM_EVT-1:0] evt;
    logic                    stat_clr;
    logic [7:0]              rd_val;

    arc_pkg::arc_ref_src_t   ref_src_q;
    logic                    bias_on_q;
    logic                    vbus_irq_q;
    logic                    usb_rst_q;
    logic                    irq_q;

    arc_vbus_if              vbus ();

    // ------------------------------------------------------------------
    // vbus synchroniser and edge finder
    // ------------------------------------------------------------------
    arc_vbus_sync u_vbus_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .vbus_pin (vbus_pin),
        .vbus     (vbus)
    );

    // ------------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------------
    // address and data are caught independently, in either order
    assign s_axi_awready = ~aw_held_q;
    assign s_axi_wready  = ~w_held_q;
    assign aw_hs         = s_axi_awvalid & ~aw_held_q;
    assign w_hs          = s_axi_wvalid & ~w_held_q;
    // a write waits until the previous response has been taken
    assign do_write      = aw_held_q & w_held_q & ~bvalid_q;
    assign wr_sel        = arc_decode(aw_addr_q);
    // only byte lane 0 holds register bits
    assign wr_en         = do_write & w_strb0_q;

    // address holding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= {`ARC_ADDR_W{1'b0}};
        end else if (aw_hs) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
        end
    end

    // data holding; upper lanes are dropped, registers are 8 bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q  <= 1'b0;
            w_data_q  <= 8'h00;
            w_strb0_q <= 1'b0;
        end else if (w_hs) begin
            w_held_q  <= 1'b1;
            w_data_q  <= s_axi_wdata[7:0];
            w_strb0_q <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held_q <= 1'b0;
        end
    end

    // write response; unmapped addresses answer slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `ARC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            if (wr_sel == arc_pkg::arc_reg_none) begin
                bresp_q <= `ARC_RESP_SLVERR;
            end else begin
                bresp_q <= `ARC_RESP_OKAY;
            end
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    // reference control; bits 6:5 are never stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_ctl_q <= `ARC_REFCTL_RESET;
        end else if (wr_en && wr_sel == arc_pkg::arc_reg_refctl) begin
            ref_ctl_q <= w_data_q & `ARC_REFCTL_WMASK;  // [R07]
        end
    end

    // regulator control; bit 6 is the live vbus level, never stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reg_ctl_q <= `ARC_REGCTL_RESET;
        end else if (wr_en && wr_sel == arc_pkg::arc_reg_regctl) begin
            reg_ctl_q <= w_data_q & `ARC_REGCTL_WMASK;  // [R08] [R09] [R15]
        end
    end

    // block control: vbus interrupt enable, usb reset source enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `ARC_CTRL_RESET;
        end else if (wr_en && wr_sel == arc_pkg::arc_reg_ctrl) begin
            ctrl_q <= w_data_q & `ARC_CTRL_WMASK;
        end
    end

    // interrupt mask, same layout as status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_q <= `ARC_MASK_RESET;
        end else if (wr_en && wr_sel == arc_pkg::arc_reg_mask) begin
            mask_q <= {6'h00, w_data_q[`ARC_NUM_EVT-1:0]};
        end
    end

    // ------------------------------------------------------------------
    // sticky event status, cleared by a read
    // ------------------------------------------------------------------
    assign evt[`ARC_EVT_RISE_BIT] = vbus.rise;
    assign evt[`ARC_EVT_FALL_BIT] = vbus.fall;
    assign stat_clr = ar_hs & (rd_sel == arc_pkg::arc_reg_status);

    // an edge in the very cycle of the clearing read wins over the clear
    for (genvar i = 0; i < `ARC_NUM_EVT; i++) begin : g_stat
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                stat_q[i] <= 1'b0;
            end else if (evt[i]) begin
                stat_q[i] <= 1'b1;
            end else if (stat_clr) begin
                stat_q[i] <= 1'b0;
            end
        end
    end

    // level interrupt while any unmasked status bit is set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_q & mask_q[`ARC_NUM_EVT-1:0]);
        end
    end

    // ------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------
    assign s_axi_arready = ~rvalid_q;
    assign ar_hs         = s_axi_arvalid & ~rvalid_q;
    assign rd_sel        = arc_decode(s_axi_araddr);

    // read value of the addressed register
    always_comb begin
        rd_val = 8'h00;
        case (rd_sel)
            arc_pkg::arc_reg_refctl: begin
                rd_val = ref_ctl_q & `ARC_REFCTL_WMASK;  // [R07]
            end
            arc_pkg::arc_reg_regctl: begin
                rd_val = reg_ctl_q;
                rd_val[`ARC_VBUS_STAT_BIT] = vbus.level;  // [R10] [R15]
            end
            arc_pkg::arc_reg_ctrl: begin
                rd_val = ctrl_q;
            end
            arc_pkg::arc_reg_status: begin
                rd_val = {6'h00, stat_q};
            end
            arc_pkg::arc_reg_mask: begin
                rd_val = mask_q;
            end
            default: begin
                rd_val = 8'h00;
            end
        endcase
    end

    // read data held until rready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q  <= `ARC_RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
        end else if (ar_hs) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h00_0000, rd_val};
            if (rd_sel == arc_pkg::arc_reg_none) begin
                rresp_q <= `ARC_RESP_SLVERR;
            end else begin
                rresp_q <= `ARC_RESP_OKAY;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp  = rresp_q;
    assign s_axi_rdata  = rdata_q;

    // ------------------------------------------------------------------
    // analog control levels
    // ------------------------------------------------------------------
    // override beats the source select bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_src_q <= arc_pkg::arc_ref_pin;
        end else if (ref_ctl_q[`ARC_REG_OVR_BIT]) begin
            ref_src_q <= arc_pkg::arc_ref_ireg;  // [R02]
        end else if (ref_ctl_q[`ARC_REF_SRC_BIT]) begin
            ref_src_q <= arc_pkg::arc_ref_vdd;  // [R01]
        end else begin
            ref_src_q <= arc_pkg::arc_ref_pin;  // [R01]
        end
    end

    // bias follows peripheral requests without any software write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bias_on_q <= 1'b0;
        end else begin
            bias_on_q <= ref_ctl_q[`ARC_BIAS_EN_BIT] | bias_request;  // [R06]
        end
    end

    assign ref_source     = ref_src_q;
    assign ref_gain_2x    = ~ref_ctl_q[`ARC_REF_GAIN_BIT];  // [R03]
    assign ref_buffer_on  = ref_ctl_q[`ARC_REF_BUF_EN_BIT];  // [R04]
    assign ref_pin_drive  = ref_ctl_q[`ARC_REF_BUF_EN_BIT];  // [R04]
    assign temp_sensor_on = ref_ctl_q[`ARC_TEMP_EN_BIT];  // [R05]
    assign bias_gen_on    = bias_on_q;

    // input regulator: disable bit is active high, reset leaves it on
    assign input_regulator_on = ~reg_ctl_q[`ARC_IREG_DIS_BIT];  // [R08] [R14]
    assign input_regulator_lp = reg_ctl_q[`ARC_IREG_LP_BIT];  // [R09] [R16]

    // ------------------------------------------------------------------
    // vbus edge interrupt and usb reset request
    // ------------------------------------------------------------------
    // pure pulses, no pending state: a missed pulse cannot be recovered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vbus_irq_q <= 1'b0;
            usb_rst_q  <= 1'b0;
        end else begin
            vbus_irq_q <= (vbus.rise | vbus.fall)
                          & ctrl_q[`ARC_VBUS_IRQ_EN_BIT];  // [R11] [R12]
            usb_rst_q  <= (vbus.rise | vbus.fall)
                          & ctrl_q[`ARC_USB_RST_EN_BIT];  // [R13]
        end
    end

    assign vbus_irq      = vbus_irq_q;
    assign usb_sys_reset = usb_rst_q;
    assign irq           = irq_q;

endmodule : arc_top

`default_nettype wire

// [hdl/arc_vbus_if.sv]
// Purpose: carries the synchronised vbus level and its edge pulses
// Assumes: single clock domain
// Notes:   pulses last one clock
`default_nettype none

interface arc_vbus_if;
    logic level;   // synchronised vbus level
    logic rise;    // one-cycle pulse on a rising edge
    logic fall;    // one-cycle pulse on a falling edge

    modport src (output level, output rise, output fall);
    modport dst (input  level, input  rise, input  fall);
endinterface : arc_vbus_if

`default_nettype wire

// [hdl/arc_vbus_sync.sv]
// Purpose: synchronise the vbus pin and find its edges
// Assumes: vbus_pin is asynchronous to aclk
// Notes:   two-flop synchroniser, then a history flop for edge detection
`default_nettype none

module arc_vbus_sync (
    input  wire logic     aclk,
    input  wire logic     aresetn,
    input  wire logic     vbus_pin,
    arc_vbus_if.src       vbus
);

    logic meta_q;   // first stage, read only by sync_q
    logic sync_q;
    logic prev_q;

    // ------------------------------------------------------------------
    // synchroniser and history
    // ------------------------------------------------------------------
    // only sync_q and prev_q are compared, never meta_q
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= vbus_pin;
            sync_q <= meta_q;      // [R17]
            prev_q <= sync_q;
        end
    end

    // edges by comparing successive synchronised samples
    assign vbus.level = sync_q;
    assign vbus.rise  = sync_q & ~prev_q;  // [R17]
    assign vbus.fall  = ~sync_q & prev_q;  // [R17]

endmodule : arc_vbus_sync

`default_nettype wire
